/* File: src/pxe_bus_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One secondary bus: upper lanes plus base timing references
// ----------------------------------------------------------------
interface pxe_bus_if (
   input logic clk,
   input logic rst_n
);
   import pxe_pkg::*;

   // Base interface timing, owned by the base logic (active low)
   logic frame_n;
   logic devsel_n;
   logic irdy_n;
   logic trdy_n;
   // Drive sides of the two parties
   pxe_pins_s dev;
   pxe_pins_s far;
   // Resolved line levels
   logic [PXE_AD_W-1:0] ad;
   logic [PXE_BE_W-1:0] cbe_n;
   logic par64;
   logic req64_n;
   logic ack64_n;

   // Undriven lines float high through the board pull-ups
   assign ad = dev.ad_oe ? dev.ad : (far.ad_oe ? far.ad : PXE_AD_PULL);
   assign cbe_n = dev.cbe_oe ? dev.cbe_n :
                  (far.cbe_oe ? far.cbe_n : PXE_BE_PULL);
   assign par64 = dev.par_oe ? dev.par : (far.par_oe ? far.par : 1'b1);
   assign req64_n = dev.req_oe ? dev.req_n :
                    (far.req_oe ? far.req_n : 1'b1);
   assign ack64_n = dev.ack_oe ? dev.ack_n :
                    (far.ack_oe ? far.ack_n : 1'b1);

   modport dev_mp (
      input frame_n, devsel_n, irdy_n, trdy_n,
      input ad, cbe_n, par64, req64_n, ack64_n,
      output dev
   );
   modport far_mp (
      input frame_n, devsel_n, irdy_n, trdy_n,
      input ad, cbe_n, par64, req64_n, ack64_n,
      output far
   );
endinterface

/* File: src/pxe_dev_end.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module pxe_fifo import pxe_pkg::*; #(
   parameter int WIDTH = PXE_WORD_W,
   parameter int DEPTH = PXE_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = $clog2(DEPTH);

   // Pointers wrap for free, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("pxe_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
      logic ready;
      logic valid;
   } pxe_fifo_s;

   pxe_fifo_s s_q;
   pxe_fifo_s s_d;
   logic push;
   logic pop;

   // Next state; flags are registered so ready leaves a flop
   always_comb begin
      s_d = s_q;
      push = in_valid_i & s_q.ready;
      pop = out_ready_i & s_q.valid;
      if (push) begin
         s_d.mem[s_q.wp] = in_data_i;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
      s_d.ready = s_d.cnt != (PW+1)'(DEPTH);
      s_d.valid = s_d.cnt != '0;
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready_o = s_q.ready;
   assign out_valid_o = s_q.valid;
   assign out_data_o = s_q.mem[s_q.rp];
endmodule

// ----------------------------------------------------------------
// Extension logic of one bus
// ----------------------------------------------------------------
module pxe_dev_lane import pxe_pkg::*; #(
   parameter int DEPTH = PXE_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Upper lanes
   pxe_bus_if.dev_mp bus,
   // Initiator controls from the base logic
   input wire logic ini_frame_nxt_i,
   input wire logic ini_wide_i,
   input wire logic ini_write_i,
   input wire logic [PXE_BE_W-1:0] ini_rd_be_n_i,
   // Target controls from the base logic
   input wire logic tgt_sel_nxt_i,
   input wire logic tgt_wide_i,
   input wire logic tgt_write_i,
   // Outgoing upper words {be_n, data}
   input wire logic [PXE_WORD_W-1:0] src_word_i,
   input wire logic src_valid_i,
   output logic src_ready_o,
   output logic up_rdy_o,
   // Incoming upper words
   output logic [PXE_AD_W-1:0] rd_data_o,
   output logic [PXE_BE_W-1:0] rd_be_n_o,
   output logic rd_valid_o,
   output logic par_err_o
);
   typedef struct packed {
      pxe_state_e st;
      pxe_pins_s pin;
      logic write;
      logic try64;
      logic loaded;
      logic [PXE_AD_W-1:0] stg_data;
      logic [PXE_BE_W-1:0] stg_be_n;
      logic [PXE_AD_W-1:0] rd_data;
      logic [PXE_BE_W-1:0] rd_be_n;
      logic rd_valid;
      logic chk;
      logic perr;
   } pxe_lane_s;

   pxe_lane_s s_q;
   pxe_lane_s s_d;
   logic fr;
   logic done;
   logic wide;
   logic nak;
   logic src;
   logic cap;
   logic fin;
   logic pop;
   logic f_valid;
   logic [PXE_WORD_W-1:0] f_word;

   // Line decode; all lines share this clock, so no synchroniser
   assign fr = ~bus.frame_n;
   assign done = ~bus.irdy_n & ~bus.trdy_n;
   // Request rises with frame before the last phase; an end that has
   // committed to a wide transfer keeps the lanes through that phase
   assign wide = ~bus.ack64_n & (~bus.req64_n | s_q.try64);
   assign nak = ~bus.devsel_n & bus.ack64_n;

   // Staging FIFO; its ready stalls the word source
   pxe_fifo #(
      .WIDTH(PXE_WORD_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(src_word_i),
      .in_valid_i(src_valid_i),
      .in_ready_o(src_ready_o),
      .out_data_o(f_word),
      .out_valid_o(f_valid),
      .out_ready_i(pop)
   );

   // Next state of the lane
   always_comb begin
      s_d = s_q;
      src = 1'b0;
      cap = 1'b0;
      fin = 1'b0;
      pop = 1'b0;
      s_d.rd_valid = 1'b0;
      s_d.chk = 1'b0;
      // Parity trails the lanes it covers by one clock
      s_d.pin.par = ^{bus.ad, bus.cbe_n};
      s_d.pin.par_oe = s_q.pin.ad_oe;
      s_d.perr = s_q.chk &
                 (bus.par64 != ^{s_q.rd_data, s_q.rd_be_n});
      unique case (s_q.st)
         PXE_ST_IDLE: begin
            if (ini_frame_nxt_i && !fr) begin
               s_d.st = PXE_ST_INI;
               s_d.write = ini_write_i;
               s_d.try64 = ini_wide_i;
               s_d.pin.req_oe = 1'b1;
               s_d.pin.req_n = ~ini_wide_i;
               s_d.pin.ad = PXE_ADDR_AD_HI;
               s_d.pin.cbe_n = PXE_ADDR_CBE_HI_N;
               s_d.pin.ad_oe = ini_wide_i;
               s_d.pin.cbe_oe = ini_wide_i;
            end else if (tgt_sel_nxt_i) begin
               s_d.st = PXE_ST_TGT;
               s_d.write = tgt_write_i;
               // Request is only sampled here, never driven
               s_d.try64 = tgt_wide_i & ~bus.req64_n;
               s_d.pin.ack_oe = 1'b1;
               s_d.pin.ack_n = ~s_d.try64;
            end
         end
         PXE_ST_INI: begin
            // Falls with frame, rises again with frame before the last phase
            s_d.pin.req_n = s_q.pin.req_n | ~ini_frame_nxt_i;
            if (nak) begin
               s_d.try64 = 1'b0;
            end
            s_d.pin.ad_oe = s_d.try64 & s_q.write;
            s_d.pin.cbe_oe = s_d.try64;
            if (!s_q.write) begin
               s_d.pin.cbe_n = ini_rd_be_n_i;
            end
            src = s_q.write;
            cap = done & wide & ~s_q.write;
            fin = done & ~fr;
         end
         PXE_ST_TGT: begin
            s_d.pin.ack_n = s_q.pin.ack_n | ~tgt_sel_nxt_i;
            s_d.pin.ad_oe = ~s_d.pin.ack_n & ~s_q.write;
            src = ~s_q.write;
            cap = done & wide & s_q.write;
            fin = (done & ~fr) | ~tgt_sel_nxt_i;
         end
         default: begin
            fin = 1'b1;
         end
      endcase
      // Capture a completed incoming upper word
      if (cap) begin
         s_d.rd_data = bus.ad;
         s_d.rd_be_n = bus.cbe_n;
         s_d.rd_valid = 1'b1;
         s_d.chk = 1'b1;
      end
      // Outgoing word retires only on a wide completed phase
      if (src) begin
         if (done && wide && s_q.loaded) begin
            s_d.loaded = 1'b0;
         end
         if (!s_d.loaded && f_valid) begin
            pop = 1'b1;
            s_d.loaded = 1'b1;
            s_d.stg_data = f_word[PXE_AD_W-1:0];
            s_d.stg_be_n = f_word[PXE_WORD_W-1:PXE_AD_W];
         end
         s_d.pin.ad = s_d.stg_data;
         if (s_q.st == PXE_ST_INI) begin
            s_d.pin.cbe_n = s_d.stg_be_n;
         end
      end
      // Release all lanes; a staged word waits for the next one
      if (fin) begin
         s_d.st = PXE_ST_IDLE;
         s_d.try64 = 1'b0;
         s_d.pin.ad_oe = 1'b0;
         s_d.pin.cbe_oe = 1'b0;
         s_d.pin.req_oe = 1'b0;
         s_d.pin.req_n = 1'b1;
         s_d.pin.ack_oe = 1'b0;
         s_d.pin.ack_n = 1'b1;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.st <= PXE_ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.dev = s_q.pin;
   assign up_rdy_o = s_q.loaded;
   assign rd_data_o = s_q.rd_data;
   assign rd_be_n_o = s_q.rd_be_n;
   assign rd_valid_o = s_q.rd_valid;
   assign par_err_o = s_q.perr;
endmodule

// ----------------------------------------------------------------
// Device end: one lane per secondary bus
// ----------------------------------------------------------------
module pxe_dev_end import pxe_pkg::*; #(
   parameter int DEPTH = PXE_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Secondary buses A and B
   pxe_bus_if.dev_mp bus_a,
   pxe_bus_if.dev_mp bus_b,
   // Per-bus controls, index 0 is bus A
   input wire logic [PXE_NUM_BUS-1:0] ini_frame_nxt_i,
   input wire logic [PXE_NUM_BUS-1:0] ini_wide_i,
   input wire logic [PXE_NUM_BUS-1:0] ini_write_i,
   input wire logic [PXE_NUM_BUS-1:0][PXE_BE_W-1:0] ini_rd_be_n_i,
   input wire logic [PXE_NUM_BUS-1:0] tgt_sel_nxt_i,
   input wire logic [PXE_NUM_BUS-1:0] tgt_wide_i,
   input wire logic [PXE_NUM_BUS-1:0] tgt_write_i,
   // Per-bus word streams
   input wire logic [PXE_NUM_BUS-1:0][PXE_WORD_W-1:0] src_word_i,
   input wire logic [PXE_NUM_BUS-1:0] src_valid_i,
   output logic [PXE_NUM_BUS-1:0] src_ready_o,
   output logic [PXE_NUM_BUS-1:0] up_rdy_o,
   output logic [PXE_NUM_BUS-1:0][PXE_AD_W-1:0] rd_data_o,
   output logic [PXE_NUM_BUS-1:0][PXE_BE_W-1:0] rd_be_n_o,
   output logic [PXE_NUM_BUS-1:0] rd_valid_o,
   output logic [PXE_NUM_BUS-1:0] par_err_o
);
   // Two lanes share nothing but the clock and reset
   pxe_dev_lane #(.DEPTH(DEPTH)) u_lane_a (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .bus(bus_a),
      .ini_frame_nxt_i(ini_frame_nxt_i[0]),
      .ini_wide_i(ini_wide_i[0]),
      .ini_write_i(ini_write_i[0]),
      .ini_rd_be_n_i(ini_rd_be_n_i[0]),
      .tgt_sel_nxt_i(tgt_sel_nxt_i[0]),
      .tgt_wide_i(tgt_wide_i[0]),
      .tgt_write_i(tgt_write_i[0]),
      .src_word_i(src_word_i[0]),
      .src_valid_i(src_valid_i[0]),
      .src_ready_o(src_ready_o[0]),
      .up_rdy_o(up_rdy_o[0]),
      .rd_data_o(rd_data_o[0]),
      .rd_be_n_o(rd_be_n_o[0]),
      .rd_valid_o(rd_valid_o[0]),
      .par_err_o(par_err_o[0])
   );

   pxe_dev_lane #(.DEPTH(DEPTH)) u_lane_b (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .bus(bus_b),
      .ini_frame_nxt_i(ini_frame_nxt_i[1]),
      .ini_wide_i(ini_wide_i[1]),
      .ini_write_i(ini_write_i[1]),
      .ini_rd_be_n_i(ini_rd_be_n_i[1]),
      .tgt_sel_nxt_i(tgt_sel_nxt_i[1]),
      .tgt_wide_i(tgt_wide_i[1]),
      .tgt_write_i(tgt_write_i[1]),
      .src_word_i(src_word_i[1]),
      .src_valid_i(src_valid_i[1]),
      .src_ready_o(src_ready_o[1]),
      .up_rdy_o(up_rdy_o[1]),
      .rd_data_o(rd_data_o[1]),
      .rd_be_n_o(rd_be_n_o[1]),
      .rd_valid_o(rd_valid_o[1]),
      .par_err_o(par_err_o[1])
   );
endmodule

/* File: src/pxe_far_end.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far party on one bus: wide initiator or wide target
// ----------------------------------------------------------------
module pxe_far_end import pxe_pkg::*; (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Upper lanes
   pxe_bus_if.far_mp bus,
   // Initiator controls from the far base logic
   input wire logic ini_frame_nxt_i,
   input wire logic ini_wide_i,
   input wire logic ini_write_i,
   input wire logic [PXE_BE_W-1:0] ini_rd_be_n_i,
   // Target controls from the far base logic
   input wire logic tgt_sel_nxt_i,
   input wire logic tgt_wide_i,
   input wire logic tgt_write_i,
   // Outgoing upper word, held by the user for each phase
   input wire logic [PXE_AD_W-1:0] src_data_i,
   input wire logic [PXE_BE_W-1:0] src_be_n_i,
   // Incoming upper words
   output logic [PXE_AD_W-1:0] rd_data_o,
   output logic [PXE_BE_W-1:0] rd_be_n_o,
   output logic rd_valid_o,
   output logic par_err_o
);
   typedef struct packed {
      pxe_state_e st;
      pxe_pins_s pin;
      logic write;
      logic try64;
      logic [PXE_AD_W-1:0] rd_data;
      logic [PXE_BE_W-1:0] rd_be_n;
      logic rd_valid;
      logic chk;
      logic perr;
   } pxe_far_s;

   pxe_far_s s_q;
   pxe_far_s s_d;
   logic fr;
   logic done;
   logic wide;
   logic cap;
   logic fin;

   assign fr = ~bus.frame_n;
   assign done = ~bus.irdy_n & ~bus.trdy_n;
   // Last phase runs with request high but stays wide once committed
   assign wide = ~bus.ack64_n & (~bus.req64_n | s_q.try64);

   // Next state; the user word is always ready, so no staging
   always_comb begin
      s_d = s_q;
      cap = 1'b0;
      fin = 1'b0;
      s_d.rd_valid = 1'b0;
      s_d.chk = 1'b0;
      s_d.pin.par = ^{bus.ad, bus.cbe_n};
      s_d.pin.par_oe = s_q.pin.ad_oe;
      s_d.perr = s_q.chk &
                 (bus.par64 != ^{s_q.rd_data, s_q.rd_be_n});
      unique case (s_q.st)
         PXE_ST_IDLE: begin
            if (ini_frame_nxt_i && !fr) begin
               s_d.st = PXE_ST_INI;
               s_d.write = ini_write_i;
               s_d.try64 = ini_wide_i;
               s_d.pin.req_oe = 1'b1;
               s_d.pin.req_n = ~ini_wide_i;
               s_d.pin.ad = PXE_ADDR_AD_HI;
               s_d.pin.cbe_n = PXE_ADDR_CBE_HI_N;
               s_d.pin.ad_oe = ini_wide_i;
               s_d.pin.cbe_oe = ini_wide_i;
            end else if (tgt_sel_nxt_i) begin
               s_d.st = PXE_ST_TGT;
               s_d.write = tgt_write_i;
               s_d.try64 = tgt_wide_i & ~bus.req64_n;
               s_d.pin.ack_oe = 1'b1;
               s_d.pin.ack_n = ~s_d.try64;
            end
         end
         PXE_ST_INI: begin
            s_d.pin.req_n = s_q.pin.req_n | ~ini_frame_nxt_i;
            if (!bus.devsel_n && bus.ack64_n) begin
               s_d.try64 = 1'b0;
            end
            s_d.pin.ad_oe = s_d.try64 & s_q.write;
            s_d.pin.cbe_oe = s_d.try64;
            s_d.pin.ad = src_data_i;
            s_d.pin.cbe_n = s_q.write ? src_be_n_i : ini_rd_be_n_i;
            cap = done & wide & ~s_q.write;
            fin = done & ~fr;
         end
         PXE_ST_TGT: begin
            s_d.pin.ack_n = s_q.pin.ack_n | ~tgt_sel_nxt_i;
            s_d.pin.ad_oe = ~s_d.pin.ack_n & ~s_q.write;
            s_d.pin.ad = src_data_i;
            cap = done & wide & s_q.write;
            fin = (done & ~fr) | ~tgt_sel_nxt_i;
         end
         default: begin
            fin = 1'b1;
         end
      endcase
      if (cap) begin
         s_d.rd_data = bus.ad;
         s_d.rd_be_n = bus.cbe_n;
         s_d.rd_valid = 1'b1;
         s_d.chk = 1'b1;
      end
      // End of transaction frees every extension line but parity, which is freed one clock later
      if (fin) begin
         s_d.st = PXE_ST_IDLE;
         s_d.try64 = 1'b0;
         s_d.pin.ad_oe = 1'b0;
         s_d.pin.cbe_oe = 1'b0;
         s_d.pin.req_oe = 1'b0;
         s_d.pin.req_n = 1'b1;
         s_d.pin.ack_oe = 1'b0;
         s_d.pin.ack_n = 1'b1;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.st <= PXE_ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.far = s_q.pin;
   assign rd_data_o = s_q.rd_data;
   assign rd_be_n_o = s_q.rd_be_n;
   assign rd_valid_o = s_q.rd_valid;
   assign par_err_o = s_q.perr;
endmodule

/* File: src/pxe_pkg.sv */
// ----------------------------------------------------------------
// Shared constants and types of the 64-bit lane extension
// ----------------------------------------------------------------
package pxe_pkg;
   localparam int PXE_AD_W = 32;
   localparam int PXE_BE_W = 4;
   localparam int PXE_WORD_W = PXE_AD_W + PXE_BE_W;
   localparam int PXE_FIFO_DEPTH = 16;
   localparam int PXE_NUM_BUS = 2;
   // Upper lanes during a wide address phase (no dual address cycle)
   localparam logic [PXE_AD_W-1:0] PXE_ADDR_AD_HI = 32'h0000_0000;
   localparam logic [PXE_BE_W-1:0] PXE_ADDR_CBE_HI_N = 4'h0;
   // Level seen on a line that nobody drives (pull-up)
   localparam logic [PXE_AD_W-1:0] PXE_AD_PULL = 32'hFFFF_FFFF;
   localparam logic [PXE_BE_W-1:0] PXE_BE_PULL = 4'hF;

   typedef enum logic [2:0] {
      PXE_ST_IDLE = 3'h1,
      PXE_ST_INI = 3'h2,
      PXE_ST_TGT = 3'h4
   } pxe_state_e;

   // Drive side of every extension pin: value and output enable
   typedef struct packed {
      logic [PXE_AD_W-1:0] ad;
      logic ad_oe;
      logic [PXE_BE_W-1:0] cbe_n;
      logic cbe_oe;
      logic par;
      logic par_oe;
      logic req_n;
      logic req_oe;
      logic ack_n;
      logic ack_oe;
   } pxe_pins_s;
endpackage

/* File: tb/pxe_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Wire checks on the upper lanes of bus A
// ----------------------------------------------------------------
module pxe_properties import pxe_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Base timing and drive sides
   input wire logic frame_n,
   input wire logic devsel_n,
   input wire logic irdy_n,
   input wire logic trdy_n,
   input wire pxe_pins_s dev,
   input wire pxe_pins_s far,
   // Resolved lines
   input wire logic [PXE_AD_W-1:0] ad,
   input wire logic [PXE_BE_W-1:0] cbe_n,
   input wire logic par64,
   input wire logic req64_n,
   input wire logic ack64_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // A data phase completing with both wide lines low
   logic wide_done;
   assign wide_done = !irdy_n && !trdy_n && !req64_n && !ack64_n;

   a_req_fall: assert property ($fell(req64_n) |-> $fell(frame_n))
      else $error("wide request fell apart from frame");
   a_req_rise: assert property ($rose(req64_n) |-> $rose(frame_n))
      else $error("wide request rose apart from frame");
   a_ack_fall: assert property ($fell(ack64_n) |-> $fell(devsel_n))
      else $error("wide acknowledge fell apart from select");
   a_ack_rise: assert property ($rose(ack64_n) |-> $rose(devsel_n))
      else $error("wide acknowledge rose apart from select");
   a_ack_needs_req: assert property ($fell(ack64_n) |-> !$past(req64_n))
      else $error("acknowledge without a wide request");
   a_wide_lanes: assert property (wide_done |->
      (dev.ad_oe ^ far.ad_oe) && (dev.cbe_oe || far.cbe_oe))
      else $error("wide phase without upper lanes driven");
   a_par_even: assert property ((dev.par_oe || far.par_oe) |->
      par64 == ^{$past(ad), $past(cbe_n)})
      else $error("upper parity not even");
   a_dev_par_lag: assert property (dev.par_oe == $past(dev.ad_oe))
      else $error("device parity not one clock behind");
   a_far_par_lag: assert property (far.par_oe == $past(far.ad_oe))
      else $error("far parity not one clock behind");
   a_narrow_release: assert property ((!devsel_n && ack64_n) |->
      ##2 !(dev.ad_oe || far.ad_oe || dev.cbe_oe || far.cbe_oe))
      else $error("upper lanes held without acknowledge");
   a_single_ad: assert property (!(dev.ad_oe && far.ad_oe))
      else $error("both ends drive the upper lanes");

   // Main scenarios seen on the wire
   c_dev_sends: cover property (wide_done && dev.ad_oe);
   c_far_sends: cover property (wide_done && far.ad_oe);
   c_fallback: cover property (!devsel_n && ack64_n && !req64_n);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Device end against one far end on each bus
// ----------------------------------------------------------------
module tb;
   import pxe_pkg::*;
   localparam int DEPTH = 4;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int perr_cnt = 0;
   logic [3:0] rbe = 4'h6;
   logic [1:0] d_fnxt = '0, d_wide = '0, d_write = '0;
   logic [1:0] d_sel = '0, d_twide = '0, d_twrite = '0;
   logic [1:0] f_fnxt = '0, f_wide = '0, f_write = '0;
   logic [1:0] f_sel = '0, f_twide = '0, f_twrite = '0;
   logic [1:0][PXE_WORD_W-1:0] src_word = '0;
   logic [1:0] src_valid = '0;
   logic [1:0][PXE_AD_W-1:0] f_data = '0;
   logic [1:0][PXE_BE_W-1:0] f_be = '0;
   logic [1:0] fr_q, dv_q, irdy_n = 2'h3, trdy_n = 2'h3;
   wire [1:0] src_ready, up_rdy, d_rvalid, d_perr, f_rvalid, f_perr;
   wire [1:0][PXE_AD_W-1:0] d_rdata, f_rdata;
   wire [1:0][PXE_BE_W-1:0] d_rbe, f_rbe;
   logic [35:0] exp[$], got[$];

   // Clock of 100 ns
   always #50 sys_clk = ~sys_clk;

   pxe_bus_if i_pxe_bus_if[2] (.clk(sys_clk), .rst_n(reset_n));

   pxe_dev_end #(.DEPTH(DEPTH)) i_pxe_dev_end (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .bus_a(i_pxe_bus_if[0]), .bus_b(i_pxe_bus_if[1]),
      .ini_frame_nxt_i(d_fnxt), .ini_wide_i(d_wide), .ini_write_i(d_write),
      .ini_rd_be_n_i({rbe, rbe}), .tgt_sel_nxt_i(d_sel),
      .tgt_wide_i(d_twide), .tgt_write_i(d_twrite), .src_word_i(src_word),
      .src_valid_i(src_valid), .src_ready_o(src_ready), .up_rdy_o(up_rdy),
      .rd_data_o(d_rdata), .rd_be_n_o(d_rbe), .rd_valid_o(d_rvalid),
      .par_err_o(d_perr));

   for (genvar g = 0; g < 2; g++) begin : g_bus
      assign i_pxe_bus_if[g].frame_n = fr_q[g];
      assign i_pxe_bus_if[g].devsel_n = dv_q[g];
      assign i_pxe_bus_if[g].irdy_n = irdy_n[g];
      assign i_pxe_bus_if[g].trdy_n = trdy_n[g];
      // Base frame and select flops; their D inputs feed the ends too
      always @(posedge sys_clk or negedge reset_n) begin
         fr_q[g] <= !reset_n || !(d_fnxt[g] || f_fnxt[g]);
         dv_q[g] <= !reset_n || !(d_sel[g] || f_sel[g]);
      end
      pxe_far_end i_pxe_far_end (
         .sys_clk_i(sys_clk), .reset_n_i(reset_n), .bus(i_pxe_bus_if[g]),
         .ini_frame_nxt_i(f_fnxt[g]), .ini_wide_i(f_wide[g]),
         .ini_write_i(f_write[g]), .ini_rd_be_n_i(rbe),
         .tgt_sel_nxt_i(f_sel[g]), .tgt_wide_i(f_twide[g]),
         .tgt_write_i(f_twrite[g]), .src_data_i(f_data[g]),
         .src_be_n_i(f_be[g]), .rd_data_o(f_rdata[g]), .rd_be_n_o(f_rbe[g]),
         .rd_valid_o(f_rvalid[g]), .par_err_o(f_perr[g]));
   end

   pxe_properties i_pxe_properties (
      .clk(sys_clk), .rst_n(reset_n),
      .frame_n(i_pxe_bus_if[0].frame_n), .devsel_n(i_pxe_bus_if[0].devsel_n),
      .irdy_n(i_pxe_bus_if[0].irdy_n), .trdy_n(i_pxe_bus_if[0].trdy_n),
      .dev(i_pxe_bus_if[0].dev), .far(i_pxe_bus_if[0].far),
      .ad(i_pxe_bus_if[0].ad), .cbe_n(i_pxe_bus_if[0].cbe_n),
      .par64(i_pxe_bus_if[0].par64), .req64_n(i_pxe_bus_if[0].req64_n),
      .ack64_n(i_pxe_bus_if[0].ack64_n));

   // Collect captured words; one transfer runs at a time, so one queue
   always @(negedge sys_clk) begin
      for (int b = 0; b < 2; b++) begin
         if (d_rvalid[b] === 1'b1) got.push_back({d_rbe[b], d_rdata[b]});
         if (f_rvalid[b] === 1'b1) got.push_back({f_rbe[b], f_rdata[b]});
         if (d_perr[b] !== 1'b0 || f_perr[b] !== 1'b0) perr_cnt++;
      end
   end

   // Cut a hang short well beyond the hundred or so cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [35:0] word(input int k);
      return {4'(k * 5 + 1), 32'hC0DE_0000 + 32'(k * 32'h0001_0203)};
   endfunction

   // Push words back to back until refused or the limit is reached
   task automatic fill(input int b, input int limit, output int n);
      bit ok;
      n = 0;
      do begin
         @(negedge sys_clk);
         ok = src_ready[b] === 1'b1 && n < limit;
         src_valid[b] = ok;
         if (ok) begin
            src_word[b] = word(n + 8 * b);
            exp.push_back(word(n + 8 * b));
            n++;
         end
      end while (ok);
   endtask

   // One transaction; both readies wait for a staged word when the device sends
   // and complete only every other cycle, so each side sees stalls;
   // no phase ends before a read target has turned the lanes around
   task automatic txn(input int b, input bit dini, input bit wr,
                      input bit twide, input int n);
      int done;
      bit c;
      done = 0;
      @(negedge sys_clk);
      if (dini) begin
         d_fnxt[b] = 1'b1;
         d_wide[b] = 1'b1;
         d_write[b] = wr;
      end else begin
         f_fnxt[b] = 1'b1;
         f_wide[b] = 1'b1;
         f_write[b] = wr;
      end
      @(negedge sys_clk);
      for (int t = 0; t < 100 && done < n; t++) begin
         c = t[0] && t > 1 && dv_q[b] === 1'b0 &&
             (dini != wr || up_rdy[b] === 1'b1);
         irdy_n[b] = !c;
         trdy_n[b] = !c;
         if (done < exp.size()) begin
            f_data[b] = exp[done][31:0];
            f_be[b] = exp[done][35:32];
         end
         if (dini) begin
            d_fnxt[b] = (done + c) < n - 1;
            f_sel[b] = (done + c) < n;
            f_twide[b] = twide;
            f_twrite[b] = wr;
         end else begin
            f_fnxt[b] = (done + c) < n - 1;
            d_sel[b] = (done + c) < n;
            d_twide[b] = twide;
            d_twrite[b] = wr;
         end
         done += c;
         @(negedge sys_clk);
      end
      irdy_n[b] = 1'b1;
      trdy_n[b] = 1'b1;
   endtask

   // Compare what arrived with what was sent; reads compare data only
   task automatic settle(input bit wr);
      repeat (4) @(negedge sys_clk);
      chk(36'(got.size()), 36'(exp.size()));
      for (int k = 0; k < exp.size() && k < got.size(); k++)
         chk(wr ? got[k] : {4'h0, got[k][31:0]},
             wr ? exp[k] : {4'h0, exp[k][31:0]});
      got.delete();
      exp.delete();
   endtask

   task automatic sc_fill_drain(input int b);
      int n;
      fill(b, 40, n);
      chk(36'(n), 36'(DEPTH));
      txn(b, 1'b1, 1'b1, 1'b1, n);
      settle(1'b1);
      chk(36'(up_rdy[b]), 36'h0);
   endtask

   task automatic sc_far_write();
      for (int k = 0; k < 3; k++) exp.push_back(word(20 + k));
      txn(0, 1'b0, 1'b1, 1'b1, 3);
      settle(1'b1);
   endtask

   task automatic sc_dev_read();
      int n;
      fill(0, 2, n);
      txn(0, 1'b0, 1'b0, 1'b1, 2);
      settle(1'b0);
   endtask

   task automatic sc_far_read();
      for (int k = 0; k < 2; k++) exp.push_back(word(30 + k));
      txn(0, 1'b1, 1'b0, 1'b1, 2);
      settle(1'b0);
   endtask

   // Narrow target: the staged word must stay put and nothing arrive
   task automatic sc_no_ack();
      int n;
      fill(0, 1, n);
      exp.delete();
      txn(0, 1'b1, 1'b1, 1'b0, 2);
      settle(1'b1);
      chk(36'(up_rdy[0]), 36'h1);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      sc_fill_drain(0);
      sc_fill_drain(1);
      sc_far_write();
      sc_dev_read();
      sc_far_read();
      sc_no_ack();
      chk(36'(perr_cnt), 36'h0);
      tally_and_finish();
   end
endmodule
